// ### design/acc_pkg.sv
// converter configuration, clock divider and settling delay constants
// assumes an 8-bit register port on the controller's dedicated bus
package acc_pkg;
  // register offsets
  localparam logic [4:0] OFF_GLOBAL_CONFIG = 5'h01;
  localparam logic [4:0] OFF_CLOCK_DIVIDER = 5'h02;
  localparam logic [4:0] OFF_SETTLE_DELAY = 5'h03;
  // global config field positions
  localparam int BIT_CONVERTER_ENABLE = 0;
  localparam int BIT_CONFIG_SPARE = 1;
  localparam int BIT_CYCLE_DONE_IRQ_ENABLE = 2;
  localparam int BIT_SMOOTHING_FILTER_ENABLE = 5;
  localparam logic [1:0] CONFIG_TOP_READ = 2'h2;
  // reset values
  localparam logic [5:0] RST_CLOCK_DIVISOR = 6'h13;
  localparam logic [2:0] RST_SETTLE_DELAY_SELECT = 3'h6;
  // filter: new = old + (sample - old) / 2^shift
  localparam int FILTER_SHIFT = 2;
  // settling delay count per select code
  function automatic logic [9:0] settle_count(input logic [2:0] sel);
    case (sel)
      3'h1: settle_count = 10'h008;
      3'h2: settle_count = 10'h010;
      3'h3: settle_count = 10'h020;
      3'h4: settle_count = 10'h040;
      3'h5: settle_count = 10'h080;
      3'h6: settle_count = 10'h100;
      3'h7: settle_count = 10'h200;
      default: settle_count = 10'h008; // reserved code treated as shortest
    endcase
  endfunction
endpackage

// ### design/acc_ctrl.sv
// converter configuration, clock divider, settling delay and smoothing filter
// assumes core handshakes (samples, channel switch, cycle done) share i_clk
// Overview of operation
// - filter enabled: o_channel_result carries smoothed results
// - filter ignored while converter disabled
// - irq enable gates cycle-done interrupt
// - enable bit zero powers converter down
// - converter clock equals clock over divisor+1
// - wait settling delay after channel switch
// - delay is count times divisor+1 clocks
// - flag set when cycle measurements complete
// - enable bit cleared by domain reset
`timescale 1ns/10ps
module acc_ctrl #(
  parameter int DATA_W = 10
) (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic [4:0] i_addr,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata,
  input wire logic i_chan_switch,
  input wire logic i_sample_valid,
  input wire logic [DATA_W-1:0] i_sample,
  input wire logic i_cycle_done,
  input wire logic i_flag_clear,
  output logic o_converter_enable,
  output logic o_conv_clk_en,
  output logic o_conv_start,
  output logic [DATA_W-1:0] o_channel_result,
  output logic o_result_valid,
  output logic o_cycle_done_flag,
  output logic o_irq
);
  if (DATA_W < 4 || DATA_W > 16) begin : g_width_check
    $error("DATA_W must be 4 to 16");
  end

  logic enable_q, filter_en_q, irq_en_q, spare_q;
  logic [5:0] divisor_q;
  logic [2:0] settle_sel_q;
  logic [7:0] rdata_q;
  logic [5:0] div_cnt_q;
  logic tick_q;
  logic [15:0] settle_cnt_q;
  logic settle_busy_q, start_q;
  logic [DATA_W-1:0] result_q;
  logic result_valid_q, flag_q, irq_q;

  // register decode
  wire wr_cfg = i_wr && (i_addr == acc_pkg::OFF_GLOBAL_CONFIG);
  wire wr_div = i_wr && (i_addr == acc_pkg::OFF_CLOCK_DIVIDER);
  wire wr_dly = i_wr && (i_addr == acc_pkg::OFF_SETTLE_DELAY);
  wire [7:0] cfg_view = {acc_pkg::CONFIG_TOP_READ, filter_en_q, 2'h0, irq_en_q, spare_q,
                         enable_q};
  wire [7:0] rd_mux = (i_addr == acc_pkg::OFF_GLOBAL_CONFIG) ? cfg_view :
                      (i_addr == acc_pkg::OFF_CLOCK_DIVIDER) ? {2'h0, divisor_q} :
                      (i_addr == acc_pkg::OFF_SETTLE_DELAY) ? {5'h00, settle_sel_q} : 8'h00;

  // config registers; reset clears enable, irq and filter
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      enable_q <= 1'b0;
      filter_en_q <= 1'b0;
      irq_en_q <= 1'b0;
      spare_q <= 1'b0;
      divisor_q <= acc_pkg::RST_CLOCK_DIVISOR;
      settle_sel_q <= acc_pkg::RST_SETTLE_DELAY_SELECT;
    end else begin
      if (wr_cfg) begin
        enable_q <= i_wdata[acc_pkg::BIT_CONVERTER_ENABLE];
        filter_en_q <= i_wdata[acc_pkg::BIT_SMOOTHING_FILTER_ENABLE];
        irq_en_q <= i_wdata[acc_pkg::BIT_CYCLE_DONE_IRQ_ENABLE];
        spare_q <= i_wdata[acc_pkg::BIT_CONFIG_SPARE];
      end
      if (wr_div) divisor_q <= i_wdata[5:0];
      if (wr_dly) settle_sel_q <= i_wdata[2:0];
    end
  end

  // read data registered one cycle after the read strobe
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) rdata_q <= 8'h00;
    else if (i_rd) rdata_q <= rd_mux;
  end

  // converter clock enable: one pulse every divisor+1 clocks, idle when off
  wire div_wrap = (div_cnt_q >= divisor_q);
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      div_cnt_q <= 6'h00;
      tick_q <= 1'b0;
    end else if (!enable_q) begin
      div_cnt_q <= 6'h00;
      tick_q <= 1'b0;
    end else begin
      div_cnt_q <= div_wrap ? 6'h00 : div_cnt_q + 6'h01;
      tick_q <= div_wrap;
    end
  end

  // settling delay in controller clocks; a new switch restarts the wait
  wire [15:0] settle_load = 16'(acc_pkg::settle_count(settle_sel_q) *
                                ({10'h000, divisor_q} + 16'h0001));
  wire settle_done = settle_busy_q && (settle_cnt_q == 16'h0001);
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      settle_cnt_q <= 16'h0000;
      settle_busy_q <= 1'b0;
      start_q <= 1'b0;
    end else if (!enable_q) begin
      settle_busy_q <= 1'b0;
      start_q <= 1'b0;
    end else if (i_chan_switch) begin
      settle_cnt_q <= settle_load;
      settle_busy_q <= 1'b1;
      start_q <= 1'b0;
    end else begin
      if (settle_busy_q) settle_cnt_q <= settle_cnt_q - 16'h0001;
      settle_busy_q <= settle_busy_q && !settle_done;
      start_q <= settle_done;
    end
  end

  // first-order low-pass; relies on slow sample rate, hence divisor above 15
  wire filter_on = filter_en_q && enable_q;
  wire signed [DATA_W:0] diff = $signed({1'b0, i_sample}) - $signed({1'b0, result_q});
  wire signed [DATA_W:0] step = diff >>> acc_pkg::FILTER_SHIFT;
  wire [DATA_W-1:0] smoothed = DATA_W'($signed({1'b0, result_q}) + step);
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      result_q <= '0;
      result_valid_q <= 1'b0;
    end else begin
      result_valid_q <= i_sample_valid && enable_q;
      if (i_sample_valid && enable_q) result_q <= filter_on ? smoothed : i_sample;
    end
  end

  // cycle-done flag: set beats clear in the same cycle; irq is a level
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      flag_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      flag_q <= (i_cycle_done && enable_q) || (flag_q && !i_flag_clear);
      irq_q <= flag_q && irq_en_q;
    end
  end

  assign o_rdata = rdata_q;
  assign o_converter_enable = enable_q;
  assign o_conv_clk_en = tick_q;
  assign o_conv_start = start_q;
  assign o_channel_result = result_q;
  assign o_result_valid = result_valid_q;
  assign o_cycle_done_flag = flag_q;
  assign o_irq = irq_q;

  // checker helper: age of a switch taken with divisor 4 and select 1;
  // a counter instead of a long repetition keeps the property cheap
  logic chk_armed_q;
  logic [5:0] chk_age_q;
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      chk_armed_q <= 1'b0;
      chk_age_q <= 6'h00;
    end else if (!enable_q) begin
      chk_armed_q <= 1'b0;
    end else if (i_chan_switch) begin
      chk_armed_q <= (divisor_q == 6'h04) && (settle_sel_q == 3'h1);
      chk_age_q <= 6'h01;
    end else if (chk_armed_q && (chk_age_q != 6'h3F)) begin
      chk_age_q <= chk_age_q + 6'h01;
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);

  a_irq_follows: assert property (o_irq == $past(flag_q && irq_en_q))
    else $error("irq does not follow flag and enable");
  a_irq_gated: assert property (!irq_en_q ##1 !irq_en_q |-> !o_irq)
    else $error("irq raised while disabled");
  a_flag_set_wins: assert property (i_cycle_done && enable_q |=> flag_q)
    else $error("cycle done lost");
  a_tick_off: assert property (!enable_q |=> !o_conv_clk_en)
    else $error("converter clock runs while disabled");
  a_tick_period: assert property (tick_q && enable_q && divisor_q == 6'h04 && !wr_div
    ##1 (enable_q && !wr_div) [*5] |-> tick_q)
    else $error("divider period wrong");
  a_tick_gap: assert property (tick_q && divisor_q == 6'h04 && !wr_div |=> !tick_q [*4])
    else $error("divider ticks early");
  // 8 x (4 + 1) = 40 clocks: start is seen on the 41st edge after the switch
  a_settle_time: assert property (chk_armed_q && chk_age_q == 6'h29 |-> start_q)
    else $error("settling delay wrong");
  a_settle_exact: assert property (chk_armed_q && chk_age_q == 6'h28 |-> !start_q)
    else $error("settling delay too short");
  a_start_pulse: assert property (o_conv_start |=> !o_conv_start)
    else $error("conversion start longer than one cycle");
  a_settle_early: assert property (i_chan_switch && enable_q |=> !start_q [*8])
    else $error("conversion started before settling");
  a_raw_unfiltered: assert property (i_sample_valid && enable_q && !filter_on
    |=> o_channel_result == $past(i_sample))
    else $error("unfiltered result differs");
  a_filter_applied: assert property (i_sample_valid && filter_on
    |=> o_channel_result == $past(smoothed))
    else $error("filtered result differs");
  a_enable_reset: assert property ($rose(i_arst_n) |-> !enable_q)
    else $error("enable not cleared by reset");
  a_flag_clear: assert property (i_flag_clear && !i_cycle_done |=> !flag_q)
    else $error("flag not cleared");
  a_result_hold: assert property (!i_sample_valid |=> $stable(o_channel_result))
    else $error("result changed without a sample");

  c_irq: cover property (o_irq);
  c_start: cover property (o_conv_start);
  c_filter: cover property (i_sample_valid && filter_on);
  c_set_clear: cover property (i_cycle_done && i_flag_clear && enable_q);
endmodule

// ### tb/acc_core_model.sv
// converter core model: switches channel, samples after start, 3 per cycle
// assumes enable and start come from the design on the same clock
`timescale 1ns/10ps
module acc_core_model (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_en,
  input wire logic i_start,
  output logic o_sw,
  output logic o_sv,
  output logic [9:0] o_smp,
  output logic o_done
);
  logic wait_q;
  logic [1:0] n_q;
  // acts off the falling edge, like the bench
  always @(negedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      {o_sw, o_sv, o_done, wait_q, n_q, o_smp} <= '0;
    end else begin
      {o_sw, o_sv, o_done} <= 3'h0;
      o_smp <= ~o_smp; // stale data never held
      if (!i_en) begin
        {wait_q, n_q} <= 3'h0;
      end else if (!wait_q) begin
        o_sw <= 1'b1;
        wait_q <= 1'b1;
      end else if (i_start) begin
        o_sv <= 1'b1;
        o_smp <= 10'($urandom);
        wait_q <= 1'b0;
        n_q <= (n_q == 2'h2) ? 2'h0 : n_q + 2'h1;
        o_done <= (n_q == 2'h2);
      end
    end
  end
endmodule

// ### tb/adc_config_clock_delay_ctrl_test.sv
// self-checking bench: register model on rising edge, monitor on falling
// assumes the core model answers every start with one sample
`timescale 1ns/10ps
module adc_config_clock_delay_ctrl_test;
  logic clk = 1'b0, rstn = 1'b0, wr = 1'b0, rd = 1'b0, fclr = 1'b0;
  logic [4:0] addr = '0;
  logic [7:0] wd = '0, rdata;
  logic en_o, cke, st, rv, flag, irq, sw, sv, done, rdv;
  logic [9:0] smp, res, acc_v = '0;
  logic en_m = 0, filt = 0, ie = 0, spare = 0;
  logic [5:0] div = 6'h13;
  logic [2:0] sel = 3'h6;
  int n_errors = 0, checks_done = 0, cyc = 0, lastp = 0, nst = 0;
  logic [7:0] qr[$];
  logic [15:0] qs[$], qt[$];
  acc_ctrl u_acc_ctrl (.i_clk(clk), .i_arst_n(rstn), .i_addr(addr), .i_wr(wr), .i_rd(rd),
    .i_wdata(wd), .o_rdata(rdata), .i_chan_switch(sw), .i_sample_valid(sv), .i_sample(smp),
    .i_cycle_done(done), .i_flag_clear(fclr), .o_converter_enable(en_o), .o_conv_clk_en(cke),
    .o_conv_start(st), .o_channel_result(res), .o_result_valid(rv),
    .o_cycle_done_flag(flag), .o_irq(irq));
  acc_core_model u_acc_core_model (.i_clk(clk), .i_arst_n(rstn), .i_en(en_o), .i_start(st),
    .o_sw(sw), .o_sv(sv), .o_smp(smp), .o_done(done));
  initial begin
    forever #2.5 clk = ~clk;
  end
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %0h exp %0h", $time, got, exp);
    end
  endtask
  task print_verdict();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // one access; a free cycle follows so strobes never re-rise in one step
  task acc(input logic w, input logic [4:0] a, input logic [7:0] d);
    @(negedge clk);
    {wr, rd, addr, wd} = {w, !w, a, d};
    @(negedge clk);
    {wr, rd} = 2'h0;
  endtask
  // reference model; old values used before this edge's writes land
  always @(posedge clk) begin
    cyc++;
    rdv <= rd;
    if (rd) qr.push_back(addr == 5'h01 ? {2'h2, filt, 2'h0, ie, spare, en_m} :
      addr == 5'h02 ? {2'h0, div} : addr == 5'h03 ? {5'h00, sel} : 8'h00);
    if (sw && en_m) qt.push_back(16'(cyc + (8 << (sel - 3'h1)) * (div + 1)));
    if (sv && en_m) begin
      acc_v = filt ? 10'(int'(acc_v) + ((int'(smp) - int'(acc_v)) >>> 2)) : smp;
      qs.push_back(16'(acc_v));
    end
    if (!en_m) begin
      lastp = 0;
      qt.delete();
    end else if (cke) begin
      if (lastp > 0) check(16'(cyc - lastp), 16'(div + 1));
      lastp = cyc;
    end
    if (wr && addr == 5'h01) {filt, ie, spare, en_m} = {wd[5], wd[2:0]};
    if (wr && addr == 5'h02) div = wd[5:0];
    if (wr && addr == 5'h03) sel = wd[2:0];
  end
  // run limit; the tests need about 7200 cycles
  always @(negedge clk) begin
    if (cyc > 20000) begin
      n_errors++;
      print_verdict();
    end
  end
  // outputs compared mid-cycle against the oldest note
  always @(negedge clk) begin
    if (rdv) check(16'(rdata), 16'(qr.pop_front()));
    if (rv) check(16'(res), qs.pop_front());
    if (st) check(16'(cyc), qt.pop_front());
    if (st) nst++;
  end
  initial begin
    void'($urandom(71351));
    repeat (5) @(posedge clk);
    @(negedge clk);
    rstn = 1'b1;
    for (int a = 1; a < 5; a++) acc(0, 5'(a), 8'h00);
    check(16'(en_o), 16'h0);
    $display("reset values done");
    acc(1, 5'h02, 8'h04);
    for (int s = 1; s < 8; s++) begin
      acc(1, 5'h03, 8'(s));
      acc(1, 5'h01, 8'h01);
      repeat ((8 << (s - 1)) * 5 + 30) @(negedge clk);
      acc(1, 5'h01, 8'h00);
    end
    check(16'(nst > 6), 16'h1);
    $display("settling codes done");
    acc(1, 5'h02, 8'(16 + $urandom % 8));
    acc(1, 5'h03, 8'h01);
    acc(1, 5'h01, 8'(($urandom & 8'hDA) | 8'h25));
    repeat (900) @(negedge clk);
    check(16'({flag, irq}), 16'h3);
    for (int a = 1; a < 4; a++) acc(0, 5'(a), 8'h00);
    $display("filter and irq done");
    acc(1, 5'h01, 8'h04);
    fclr = 1'b1;
    @(negedge clk);
    fclr = 1'b0;
    repeat (3) @(negedge clk);
    check(16'({flag, irq}), 16'h0);
    acc(1, 5'h01, 8'h01);
    repeat (900) @(negedge clk);
    check(16'({flag, irq}), 16'h2);
    $display("flag clear done");
    print_verdict();
  end
endmodule
